// *** hdl/leo_params.svh ***
`ifndef LEO_PARAMS_SVH
`define LEO_PARAMS_SVH

// ----------------------------------------
// Math variable range, hundredths units
// ----------------------------------------
`define LEO_MV_W 32
`define LEO_MV_MAX 32'sh63FFFFFF
`define LEO_MV_MIN 32'sh9C000001
`define LEO_MV_ONE 32'sh00000064
`define LEO_MV_RST 32'sh00000000

// ----------------------------------------
// Default sizes
// ----------------------------------------
`define LEO_NBITS 16
`define LEO_NSLOT 4

`endif

// *** hdl/leo_pkg.sv ***
`include "leo_params.svh"

package leo_pkg;

	// ----------------------------------------
	// Operator codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_PASS = 3'b000,
		OP_NOT = 3'b001,
		OP_RISE = 3'b010,
		OP_FALL = 3'b011,
		OP_NRISE = 3'b100,
		OP_NFALL = 3'b101
	} bool_op_e;

	typedef enum logic [2:0] {
		CMP_LT = 3'b000,
		CMP_GT = 3'b001,
		CMP_LE = 3'b010,
		CMP_GE = 3'b011,
		CMP_EQ = 3'b100,
		CMP_NE = 3'b101
	} cmp_op_e;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_REC = 1'b1
	} rec_state_e;

	typedef logic signed [`LEO_MV_W-1:0] mv_t;

endpackage : leo_pkg

// *** hdl/edge_op_if.sv ***
`timescale 1ns/1ps

interface edge_op_if #(
	parameter int N = 16
);
	logic tick;
	logic [N-1:0] bits;
	logic [N-1:0] prev;
	logic [N-1:0] rise;
	logic [N-1:0] fall;

	modport src (
		output tick,
		output bits,
		input prev,
		input rise,
		input fall
	);

	modport bank (
		input tick,
		input bits,
		output prev,
		output rise,
		output fall
	);
endinterface : edge_op_if

// *** hdl/edge_bank.sv ***
`timescale 1ns/1ps

module edge_bank #(
	parameter int N = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Bit states
	edge_op_if.bank port
);

	// ----------------------------------------
	// Previous-interval store per bit
	// ----------------------------------------
	for (genvar b = 0; b < N; b++)
	begin : g_bit
		logic prev_r;

		always_ff @(posedge sys_clk)
		begin
			if (!rst_n)
				prev_r <= 1'b0;
			else if (port.tick)
				prev_r <= port.bits[b];
		end

		assign port.prev[b] = prev_r;
		assign port.rise[b] = port.bits[b] & ~prev_r;
		assign port.fall[b] = ~port.bits[b] & prev_r;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_prevTrack;
		@(posedge sys_clk) disable iff (!rst_n)
		port.tick |=> port.prev == $past(port.bits);
	endproperty
	a_prevTrack: assert property (p_prevTrack) else $error("prev not captured at tick");

	property p_prevHold;
		@(posedge sys_clk) disable iff (!rst_n)
		!port.tick |=> $stable(port.prev);
	endproperty
	a_prevHold: assert property (p_prevHold) else $error("prev moved between ticks");

endmodule : edge_bank

// *** hdl/math_sat.sv ***
`timescale 1ns/1ps
`include "leo_params.svh"

module math_sat (
	// Operands
	input leo_pkg::mv_t termA,
	input leo_pkg::mv_t curMv,
	input leo_pkg::mv_t step,
	input wire logic pickBit,
	input wire logic addBit,
	// Result
	output leo_pkg::mv_t result
);
	import leo_pkg::*;

	localparam logic signed [33:0] HI = 34'(`LEO_MV_MAX);
	localparam logic signed [33:0] LO = 34'(`LEO_MV_MIN);

	logic signed [33:0] partA;
	logic signed [33:0] partB;
	logic signed [33:0] partC;
	logic signed [33:0] sum;

	// ----------------------------------------
	// Select, add, clip
	// ----------------------------------------
	always_comb
	begin
		// A 0/1 bit scales by selection, so no multiplier is built
		partA = pickBit ? 34'(termA) : 34'sh0;
		partB = pickBit ? 34'sh0 : 34'(curMv) + 34'(step);
		partC = addBit ? 34'(`LEO_MV_ONE) : 34'sh0;
		sum = partA + partB + partC;
		// Clip instead of wrap; a wrapped value would flip sign
		if (sum > HI)
			result = `LEO_MV_MAX;
		else if (sum < LO)
			result = `LEO_MV_MIN;
		else
			result = mv_t'(sum[31:0]);
	end

endmodule : math_sat

// *** hdl/logic_equation_operator_unit.sv ***
`timescale 1ns/1ps
`include "leo_params.svh"


module logic_equation_operator_unit #(
	parameter int NBITS = `LEO_NBITS,
	parameter int NSLOT = `LEO_NSLOT,
	parameter int IW = $clog2(NBITS)
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Processing interval
	input wire logic tick,
	input wire logic [NBITS-1:0] statusBits,
	// Boolean slot settings
	input leo_pkg::bool_op_e slotOp [NSLOT],
	input wire logic [NSLOT-1:0] slotGroup,
	input wire logic [IW-1:0] slotIdx [NSLOT],
	input wire logic [NBITS-1:0] slotMask [NSLOT],
	// Math settings
	input leo_pkg::mv_t mathTermA,
	input leo_pkg::mv_t mathStep,
	input wire logic [IW-1:0] mathPickIdx,
	input wire logic [IW-1:0] mathAddIdx,
	input wire logic mathAddEn,
	input leo_pkg::cmp_op_e cmpOp,
	input leo_pkg::mv_t cmpThr,
	// Event report
	input wire logic [NSLOT-1:0] reportMask,
	input wire logic reportDone,
	// Results
	output logic [NSLOT-1:0] slotOut,
	output logic [NSLOT-1:0] slotReject,
	output leo_pkg::mv_t mathVar,
	output logic cmpOut,
	output logic reportStart,
	output logic recording
);
	import leo_pkg::*;

	// ----------------------------------------
	// Edge operator bank
	// ----------------------------------------
	edge_op_if #(.N(NBITS)) eif ();

	assign eif.tick = tick;
	assign eif.bits = statusBits;

	edge_bank #(.N(NBITS)) u_edge (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.port(eif.bank)
	);

	// ----------------------------------------
	// Boolean slot evaluation
	// ----------------------------------------
	// Returns {reject, value}
	function automatic logic [1:0] evalSlot(
		input bool_op_e op,
		input logic grp,
		input logic v,
		input logic gv,
		input logic r,
		input logic f
	);
		logic x;
		x = grp ? gv : v;
		case (op)
			OP_PASS: evalSlot = {1'b0, x};
			OP_NOT: evalSlot = {1'b0, ~x};
			OP_RISE: evalSlot = grp ? 2'b10 : {1'b0, r};
			OP_FALL: evalSlot = grp ? 2'b10 : {1'b0, f};
			// Edge binds to its bit first, inversion after
			OP_NRISE: evalSlot = grp ? 2'b10 : {1'b0, ~r};
			OP_NFALL: evalSlot = grp ? 2'b10 : {1'b0, ~f};
			default: evalSlot = 2'b10;
		endcase
	endfunction : evalSlot

	logic [NSLOT-1:0] opnd;
	logic [NSLOT-1:0] grpVal;
	logic [NSLOT-1:0] slotNxt;
	logic [NSLOT-1:0] rejNxt;

	for (genvar s = 0; s < NSLOT; s++)
	begin : g_slot
		logic [1:0] res;

		assign opnd[s] = statusBits[slotIdx[s]];
		// Parenthesized group: combined result of the masked bits
		assign grpVal[s] = |(statusBits & slotMask[s]);
		assign res = evalSlot(slotOp[s], slotGroup[s], opnd[s], grpVal[s],
			eif.rise[slotIdx[s]], eif.fall[slotIdx[s]]);
		assign slotNxt[s] = res[0];
		assign rejNxt[s] = res[1];
	end

	logic [NSLOT-1:0] slotOut_r;
	logic [NSLOT-1:0] slotRej_r;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			slotOut_r <= '0;
			slotRej_r <= '0;
		end
		else if (tick)
		begin
			slotOut_r <= slotNxt;
			slotRej_r <= rejNxt;
		end
	end

	assign slotOut = slotOut_r;
	assign slotReject = slotRej_r;

	// ----------------------------------------
	// Math variable and comparison
	// ----------------------------------------
	function automatic logic cmpEval(input cmp_op_e op, input mv_t a, input mv_t b);
		case (op)
			CMP_LT: cmpEval = a < b;
			CMP_GT: cmpEval = a > b;
			CMP_LE: cmpEval = a <= b;
			CMP_GE: cmpEval = a >= b;
			CMP_EQ: cmpEval = a == b;
			CMP_NE: cmpEval = a != b;
			default: cmpEval = 1'b0;
		endcase
	endfunction : cmpEval

	mv_t mathVar_r;
	mv_t mvNxt;
	logic cmpOut_r;
	logic cmpNxt;
	logic pickBit;

	assign pickBit = statusBits[mathPickIdx];

	math_sat u_math (
		.termA(mathTermA),
		.curMv(mathVar_r),
		.step(mathStep),
		.pickBit(pickBit),
		.addBit(mathAddEn & statusBits[mathAddIdx]),
		.result(mvNxt)
	);

	// Compare sees this interval's math result, not last one
	assign cmpNxt = cmpEval(cmpOp, mvNxt, cmpThr);

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			mathVar_r <= `LEO_MV_RST;
			cmpOut_r <= 1'b0;
		end
		else if (tick)
		begin
			mathVar_r <= mvNxt;
			cmpOut_r <= cmpNxt;
		end
	end

	assign mathVar = mathVar_r;
	assign cmpOut = cmpOut_r;

	// ----------------------------------------
	// Event report trigger
	// ----------------------------------------
	rec_state_e state_r;
	rec_state_e stateNxt;
	logic reportTrig;
	logic reportStart_r;
	logic startNxt;

	assign reportTrig = |(slotNxt & reportMask);

	always_comb
	begin
		stateNxt = state_r;
		startNxt = 1'b0;
		case (state_r)
			ST_IDLE:
			begin
				if (tick && reportTrig)
				begin
					stateNxt = ST_REC;
					startNxt = 1'b1;
				end
			end
			ST_REC:
			begin
				// Retriggers while busy are dropped, not queued
				if (reportDone)
					stateNxt = ST_IDLE;
			end
			default: stateNxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state_r <= ST_IDLE;
			reportStart_r <= 1'b0;
		end
		else
		begin
			state_r <= stateNxt;
			reportStart_r <= startNxt;
		end
	end

	assign reportStart = reportStart_r;
	assign recording = (state_r == ST_REC);

	// ----------------------------------------
	// Checks on slot 0, math variable and report trigger
	// ----------------------------------------
	logic chkOpnd;
	logic chkGrp;
	logic chkPrev;
	logic chkGrpOn;
	bool_op_e chkOp;

	assign chkOpnd = opnd[0];
	assign chkGrp = grpVal[0];
	assign chkPrev = eif.prev[slotIdx[0]];
	assign chkGrpOn = slotGroup[0];
	assign chkOp = slotOp[0];

	property p_notBit;
		@(posedge sys_clk) disable iff (!rst_n)
		(tick && chkOp == OP_NOT && !chkGrpOn) |=> slotOut_r[0] == !$past(chkOpnd);
	endproperty
	a_notBit: assert property (p_notBit) else $error("NOT of bit wrong");

	property p_notGroup;
		@(posedge sys_clk) disable iff (!rst_n)
		(tick && chkOp == OP_NOT && chkGrpOn) |=> slotOut_r[0] == !$past(chkGrp);
	endproperty
	a_notGroup: assert property (p_notGroup) else $error("NOT of group wrong");

	property p_rise;
		@(posedge sys_clk) disable iff (!rst_n)
		(tick && chkOp == OP_RISE && !chkGrpOn)
			|=> slotOut_r[0] == ($past(chkOpnd) && !$past(chkPrev));
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge wrong");

	property p_nrise;
		@(posedge sys_clk) disable iff (!rst_n)
		(tick && chkOp == OP_NRISE && !chkGrpOn)
			|=> slotOut_r[0] == !($past(chkOpnd) && !$past(chkPrev));
	endproperty
	a_nrise: assert property (p_nrise) else $error("inverted rising edge wrong");

	property p_fall;
		@(posedge sys_clk) disable iff (!rst_n)
		(tick && chkOp == OP_FALL && !chkGrpOn)
			|=> slotOut_r[0] == (!$past(chkOpnd) && $past(chkPrev));
	endproperty
	a_fall: assert property (p_fall) else $error("falling edge wrong");

	property p_nfall;
		@(posedge sys_clk) disable iff (!rst_n)
		(tick && chkOp == OP_NFALL && !chkGrpOn)
			|=> slotOut_r[0] == !(!$past(chkOpnd) && $past(chkPrev));
	endproperty
	a_nfall: assert property (p_nfall) else $error("inverted falling edge wrong");

	property p_edgeGroup;
		@(posedge sys_clk) disable iff (!rst_n)
		(tick && chkGrpOn && chkOp inside {OP_RISE, OP_FALL, OP_NRISE, OP_NFALL})
			|=> slotRej_r[0] && !slotOut_r[0];
	endproperty
	a_edgeGroup: assert property (p_edgeGroup) else $error("edge on group not refused");

	property p_stable;
		@(posedge sys_clk) disable iff (!rst_n)
		!tick |=> $stable(slotOut_r) && $stable(mathVar_r) && $stable(cmpOut_r);
	endproperty
	a_stable: assert property (p_stable) else $error("result moved without tick");

	property p_range;
		@(posedge sys_clk) disable iff (!rst_n)
		mathVar_r <= `LEO_MV_MAX && mathVar_r >= `LEO_MV_MIN;
	endproperty
	a_range: assert property (p_range) else $error("math variable out of range");

	property p_cmp;
		@(posedge sys_clk) disable iff (!rst_n)
		tick |=> cmpOut_r == cmpEval($past(cmpOp), mathVar_r, $past(cmpThr));
	endproperty
	a_cmp: assert property (p_cmp) else $error("comparison result wrong");

	property p_startIdle;
		@(posedge sys_clk) disable iff (!rst_n)
		reportStart_r |-> $past(state_r) == ST_IDLE && recording;
	endproperty
	a_startIdle: assert property (p_startIdle) else $error("report restarted while busy");

	property p_busyNoStart;
		@(posedge sys_clk) disable iff (!rst_n)
		(recording && !reportDone) |=> !reportStart_r && recording;
	endproperty
	a_busyNoStart: assert property (p_busyNoStart) else $error("start during recording");

	c_rise: cover property (@(posedge sys_clk) disable iff (!rst_n)
		tick && chkOp == OP_RISE ##1 slotOut_r[0]);
	c_report: cover property (@(posedge sys_clk) disable iff (!rst_n)
		reportStart_r ##[1:20] !recording);
	c_clip: cover property (@(posedge sys_clk) disable iff (!rst_n)
		mathVar_r == `LEO_MV_MAX);
	c_reject: cover property (@(posedge sys_clk) disable iff (!rst_n)
		slotRej_r[0]);

endmodule : logic_equation_operator_unit

// *** verification/logic_equation_operator_unit_tb.sv ***
`timescale 1ns/1ps
`include "leo_params.svh"

module logic_equation_operator_unit_tb;
	import leo_pkg::*;

	// --------------------------------
	// Stimulus and observed signals
	// --------------------------------
	logic sysClk = 1'b0;
	logic rstN = 1'b0;
	logic tick = 1'b0;
	logic [15:0] statusBits = 16'h0000;
	bool_op_e slotOp [4] = '{OP_PASS, OP_PASS, OP_PASS, OP_PASS};
	logic [3:0] slotGroup = 4'h0;
	logic [3:0] slotIdx [4] = '{4'h3, 4'h3, 4'h3, 4'h3};
	logic [15:0] slotMask [4] = '{16'h0030, 16'h0030, 16'h0030, 16'h0030};
	mv_t mathTermA = 32'sh00000000;
	mv_t mathStep = 32'sh00000000;
	logic [3:0] mathPickIdx = 4'h0;
	logic [3:0] mathAddIdx = 4'h1;
	logic mathAddEn = 1'b0;
	cmp_op_e cmpOp = CMP_GT;
	mv_t cmpThr = 32'sh00000000;
	logic [3:0] reportMask = 4'h0;
	logic reportDone = 1'b0;
	logic [3:0] slotOut;
	logic [3:0] slotReject;
	mv_t mathVar;
	logic cmpOut;
	logic reportStart;
	logic recording;
	int err_count = 0;
	int n_tests = 0;

	// Rows: ops packed slot3..slot0, expected outputs after one tick
	typedef struct packed {
		logic [11:0] ops;
		logic [3:0] grp;
		logic [15:0] bits;
		logic [3:0] expOut;
		logic [3:0] expRej;
	} row_s;
	row_s rows [13] = '{
		'{12'hB1A, 4'h0, 16'h0008, 4'h9, 4'h0},
		'{12'hB1A, 4'h0, 16'h0008, 4'hC, 4'h0},
		'{12'hB1A, 4'h0, 16'h0000, 4'h6, 4'h0},
		'{12'hB1A, 4'h0, 16'h0000, 4'hC, 4'h0},
		'{12'h048, 4'hA, 16'h0010, 4'hC, 4'h0},
		'{12'h048, 4'hA, 16'h0000, 4'h6, 4'h0},
		'{12'hF9A, 4'h3, 16'h0030, 4'h0, 4'hF},
		'{12'h208, 4'h0, 16'h0008, 4'h5, 4'h0},
		'{12'hB19, 4'h1, 16'h0010, 4'h6, 4'h0},
		'{12'h4E1, 4'h0, 16'h0008, 4'h8, 4'h0},
		'{12'h8AB, 4'h0, 16'h0000, 4'h9, 4'h0},
		'{12'h644, 4'h0, 16'h0008, 4'h2, 4'h0},
		'{12'h32D, 4'h6, 16'h0000, 4'h8, 4'h6}
	};

	always #20 sysClk = ~sysClk;

	logic_equation_operator_unit u_dut (
		.sys_clk(sysClk),
		.rst_n(rstN),
		.tick(tick),
		.statusBits(statusBits),
		.slotOp(slotOp),
		.slotGroup(slotGroup),
		.slotIdx(slotIdx),
		.slotMask(slotMask),
		.mathTermA(mathTermA),
		.mathStep(mathStep),
		.mathPickIdx(mathPickIdx),
		.mathAddIdx(mathAddIdx),
		.mathAddEn(mathAddEn),
		.cmpOp(cmpOp),
		.cmpThr(cmpThr),
		.reportMask(reportMask),
		.reportDone(reportDone),
		.slotOut(slotOut),
		.slotReject(slotReject),
		.mathVar(mathVar),
		.cmpOut(cmpOut),
		.reportStart(reportStart),
		.recording(recording)
	);

	// --------------------------------
	// Shared tasks
	// --------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	// One interval; outputs are settled one step after the sampling edge
	task automatic doTick(input logic [15:0] b);
		@(posedge sysClk);
		statusBits <= b;
		tick <= 1'b1;
		@(posedge sysClk);
		tick <= 1'b0;
		#1;
	endtask : doTick

	function automatic logic cmpRef(input logic [2:0] c, input mv_t v, input mv_t t);
		case (c)
			3'h0: return v < t;
			3'h1: return v > t;
			3'h2: return v <= t;
			3'h3: return v >= t;
			3'h4: return v == t;
			3'h5: return v != t;
			default: return 1'b0;
		endcase
	endfunction : cmpRef

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	// Watchdog: the whole run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge sysClk);
		err_count++;
		conclude();
	end

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial
	begin
		repeat (15) @(posedge sysClk);
		#1;
		check(32'({slotOut, slotReject, cmpOut, reportStart, recording}), 32'h0, "reset outs");
		check(mathVar, 32'h0, "reset math");
		@(posedge sysClk);
		rstN <= 1'b1;
		$display("test reset done");

		for (int r = 0; r < 13; r++)
		begin
			for (int s = 0; s < 4; s++)
				slotOp[s] <= bool_op_e'(rows[r].ops[s*3+:3]);
			slotGroup <= rows[r].grp;
			doTick(rows[r].bits);
			check(32'(slotOut), 32'(rows[r].expOut), "slot out");
			check(32'(slotReject), 32'(rows[r].expRej), "slot reject");
		end
		// No tick: results must hold over three idle cycles
		statusBits <= 16'h0000;
		repeat (3) @(posedge sysClk);
		#1;
		check(32'(slotOut), 32'h8, "held between ticks");
		$display("test table done");

		// Trigger is dropped while a report runs
		slotOp[0] <= OP_RISE;
		reportMask <= 4'h1;
		doTick(16'h0000);
		doTick(16'h0008);
		check(32'({reportStart, recording}), 32'h3, "report start");
		@(posedge sysClk);
		#1;
		check(32'({reportStart, recording}), 32'h1, "start pulse");
		doTick(16'h0000);
		doTick(16'h0008);
		check(32'(reportStart), 32'h0, "busy trigger");
		@(posedge sysClk);
		reportDone <= 1'b1;
		@(posedge sysClk);
		reportDone <= 1'b0;
		#1;
		check(32'(recording), 32'h0, "report end");
		doTick(16'h0000);
		doTick(16'h0008);
		check(32'(reportStart), 32'h1, "restart");
		reportMask <= 4'h0;
		$display("test report done");

		// Increment path and magnitude compare against 8.00
		mathStep <= 32'sh00000064;
		cmpThr <= 32'sh00000320;
		for (int k = 1; k < 10; k++)
		begin
			doTick(16'h0000);
			check(mathVar, 32'(100 * k), "increment");
			check(32'(cmpOut), 32'(k > 8), "greater");
		end
		mathTermA <= 32'sh000004B0;
		doTick(16'h0001);
		check(mathVar, 32'h000004B0, "select");
		mathStep <= 32'sh00000000;
		mathAddEn <= 1'b1;
		doTick(16'h0002);
		check(mathVar, 32'h00000514, "bit as one");
		mathAddEn <= 1'b0;
		mathTermA <= 32'sh00001194;
		for (int t = 0; t < 3; t++)
			for (int c = 0; c < 8; c++)
			begin
				cmpThr <= 32'sh0000112C + 32'(100 * t);
				cmpOp <= cmp_op_e'(c[2:0]);
				doTick(16'h0001);
				check(32'(cmpOut), 32'(cmpRef(c[2:0], 32'sh00001194,
					32'sh0000112C + 32'(100 * t))), "compare");
			end
		mathTermA <= `LEO_MV_MAX;
		doTick(16'h0001);
		mathStep <= 32'sh00000064;
		doTick(16'h0000);
		check(mathVar, `LEO_MV_MAX, "clip high");
		mathTermA <= `LEO_MV_MIN;
		doTick(16'h0001);
		mathStep <= -32'sh00000064;
		doTick(16'h0000);
		check(mathVar, `LEO_MV_MIN, "clip low");
		$display("test math done");

		// Second reset: history cleared, a held bit reads as a new edge
		mathStep <= 32'sh00000000;
		doTick(16'h0008);
		doTick(16'h0008);
		@(posedge sysClk);
		rstN <= 1'b0;
		repeat (2) @(posedge sysClk);
		rstN <= 1'b1;
		#1;
		check(32'({slotOut, recording}), 32'h0, "mid reset");
		check(mathVar, 32'h0, "mid reset math");
		doTick(16'h0008);
		check(32'(slotOut[0]), 32'h1, "edge after reset");
		// Slot 1 watches another bit, so a wrong index shows up
		slotIdx[1] <= 4'h9;
		slotOp[1] <= OP_RISE;
		slotGroup <= 4'h0;
		doTick(16'h0208);
		check(32'(slotOut[1:0]), 32'h2, "bit index");
		$display("test rerun done");
		conclude();
	end
endmodule : logic_equation_operator_unit_tb
